/* File: verilog/smcs_csr_access.sv */
// smbus slave framing for internal csr reads and writes
`timescale 1ns/1ps
`default_nettype none
module smcs_csr_access #(
    parameter int DEPTH = smcs_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // received entries from the smbus byte engine
    input wire logic rx_valid,
    output logic rx_ready,
    input wire smcs_pkg::smcs_rx_type rx_word,
    // byte return toward the master
    input wire logic tx_req,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_nack,
    // command acceptance
    output logic cmd_nack,
    // internal csr access
    output logic csr_req,
    output logic csr_we,
    output logic [13:0] csr_addr,
    output logic [3:0] csr_be,
    output logic [31:0] csr_wdata,
    input wire logic csr_done,
    input wire logic csr_claimed,
    input wire logic [31:0] csr_rdata
);
    import smcs_pkg::*;

    typedef enum {S_IDLE, S_WAIT} smcs_state_type;

    smcs_state_type state_q;
    smcs_rx_type ent;
    logic ent_valid;
    logic ent_take;
    logic [7:0] code_q;
    logic active_q;
    logic need_cnt_q;
    logic got_data_q;
    logic [3:0] pos_q;
    logic [3:0] tx_pos_q;
    logic [7:0] cmd_q;
    logic [7:0] addr_lo_q;
    logic [ADDR_HI_W-1:0] addr_hi_q;
    logic [3:0][7:0] data_q;
    logic unclaimed_read_flag_q;
    logic unclaimed_write_flag_q;
    logic tx_ok;
    logic tx_cmd_read;
    logic launch;

    // parser drains only while idle, so a stalled access fills the fifo
    smcs_fifo #(
        .WIDTH($bits(smcs_rx_type)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .in_data(rx_word),
        .out_valid(ent_valid),
        .out_ready(ent_take),
        .out_data(ent)
    );

    assign ent_take = ent_valid && (state_q == S_IDLE);

    // next field position; data wraps so a long block keeps the last word
    function automatic logic [3:0] next_pos(input logic [3:0] p);
        next_pos = (p == POS_DATA_LAST) ? POS_DATA_FIRST : p + 4'h1;
    endfunction

    // byte shown to the master for a given position
    function automatic logic [7:0] field_byte(
        input logic [3:0] p,
        input logic [7:0] cmd,
        input logic re,
        input logic we,
        input logic [7:0] alo,
        input logic [ADDR_HI_W-1:0] ahi,
        input logic [3:0][7:0] dat
    );
        logic [3:0] di;
        di = p - POS_DATA_FIRST;
        // reserved bit five always reads zero
        if (p == POS_COUNT) begin
            field_byte = RET_COUNT;
        end else if (p == POS_CMD) begin
            field_byte = {we, re, 1'b0, cmd[4:0]};
        end else if (p == POS_ADDR_LO) begin
            field_byte = alo;
        end else if (p == POS_ADDR_HI) begin
            field_byte = {2'h0, ahi};
        end else begin
            field_byte = dat[di[1:0]];
        end
    endfunction

    // access starts at the stop of a frame that carried fields and ends
    assign launch = ent_take && (ent.kind == KIND_STOP) && active_q &&
        got_data_q && code_q[CODE_END];

    // command code handling: function, size and sequence end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            code_q <= RST_BYTE;
            active_q <= 1'b0;
            need_cnt_q <= 1'b0;
            got_data_q <= 1'b0;
        end else if (ent_take) begin
            unique case (ent.kind)
                KIND_CODE: begin
                    code_q <= ent.data;
                    active_q <= (ent.data[CODE_FUNC_MSB:CODE_FUNC_LSB] ==
                        FUNC_CSR) && (ent.data[CODE_SIZE_MSB:CODE_SIZE_LSB]
                        != SIZE_RSVD);
                    need_cnt_q <= ent.data[CODE_SIZE_MSB:CODE_SIZE_LSB] ==
                        SIZE_BLOCK;
                    got_data_q <= 1'b0;
                end
                KIND_DATA: begin
                    // the count value itself steers nothing here
                    if (need_cnt_q) begin
                        need_cnt_q <= 1'b0;
                    end else if (active_q) begin
                        got_data_q <= 1'b1;
                    end
                end
                KIND_STOP: begin
                    got_data_q <= 1'b0;
                end
                default: begin
                    got_data_q <= got_data_q;
                end
            endcase
        end
    end

    // field capture at the running position
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pos_q <= RST_POS;
            cmd_q <= RST_BYTE;
            addr_lo_q <= RST_BYTE;
            addr_hi_q <= '0;
            data_q <= '0;
        end else if (ent_take && ent.kind == KIND_CODE &&
                ent.data[CODE_START]) begin
            pos_q <= POS_CMD;
        end else if (ent_take && ent.kind == KIND_DATA && active_q &&
                !need_cnt_q) begin
            pos_q <= next_pos(pos_q);
            if (pos_q == POS_CMD) begin
                cmd_q <= ent.data;
            end else if (pos_q == POS_ADDR_LO) begin
                addr_lo_q <= ent.data;
            end else if (pos_q == POS_ADDR_HI) begin
                addr_hi_q <= ent.data[ADDR_HI_W-1:0];
            end else begin
                data_q[2'(pos_q - POS_DATA_FIRST)] <= ent.data;
            end
        end else if (state_q == S_WAIT && csr_done && !cmd_q[CMD_RNW]) begin
            pos_q <= pos_q;
        end else if (state_q == S_WAIT && csr_done) begin
            data_q <= csr_rdata; // read data lands in the return fields
        end
    end

    // access sequencer; request is held until the target answers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            csr_req <= 1'b0;
            csr_we <= 1'b0;
            csr_addr <= '0;
            csr_be <= '0;
            csr_wdata <= '0;
            cmd_nack <= 1'b0;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (launch) begin
                        state_q <= S_WAIT;
                        csr_req <= 1'b1;
                        csr_we <= !cmd_q[CMD_RNW];
                        csr_addr <= {addr_hi_q, addr_lo_q};
                        csr_be <= cmd_q[3:0];
                        csr_wdata <= data_q;
                        cmd_nack <= 1'b1;
                    end
                end
                S_WAIT: begin
                    if (csr_done) begin
                        state_q <= S_IDLE;
                        csr_req <= 1'b0;
                        cmd_nack <= 1'b0;
                    end
                end
            endcase
        end
    end

    // return path is refused while an access or unparsed bytes remain
    assign tx_ok = (state_q == S_IDLE) && !ent_valid;
    assign tx_cmd_read = tx_req && tx_ok && (tx_pos_q == POS_CMD);

    // byte return toward the master
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_pos_q <= RST_POS;
            tx_valid <= 1'b0;
            tx_data <= RST_BYTE;
            tx_nack <= 1'b0;
        end else begin
            tx_valid <= tx_req && tx_ok;
            tx_nack <= tx_req && !tx_ok;
            if (ent_take && ent.kind == KIND_CODE && ent.data[CODE_START]) begin
                tx_pos_q <= (ent.data[CODE_SIZE_MSB:CODE_SIZE_LSB] ==
                    SIZE_BLOCK) ? POS_COUNT : POS_CMD;
            end else if (tx_req && tx_ok) begin
                tx_data <= field_byte(tx_pos_q, cmd_q, unclaimed_read_flag_q, unclaimed_write_flag_q,
                    addr_lo_q, addr_hi_q, data_q);
                tx_pos_q <= (tx_pos_q == POS_DATA_LAST) ? POS_CMD :
                    tx_pos_q + 4'h1;
            end
        end
    end

    // unclaimed flags: returned once then cleared, a new set wins
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            unclaimed_read_flag_q <= 1'b0;
            unclaimed_write_flag_q <= 1'b0;
        end else begin
            if (state_q == S_WAIT && csr_done && !csr_claimed && !csr_we) begin
                unclaimed_read_flag_q <= 1'b1;
            end else if (tx_cmd_read) begin
                unclaimed_read_flag_q <= 1'b0;
            end
            if (state_q == S_WAIT && csr_done && !csr_claimed && csr_we) begin
                unclaimed_write_flag_q <= 1'b1;
            end else if (tx_cmd_read) begin
                unclaimed_write_flag_q <= 1'b0;
            end
        end
    end

    sequence s_launch;
        launch;
    endsequence

    sequence s_req_open;
        csr_req && cmd_nack;
    endsequence

    property p_launch_req;
        @(posedge clk_sys) disable iff (!rst_n)
        s_launch |=> s_req_open;
    endproperty
    a_launch_req: assert property (p_launch_req)
        else $error("access not launched after frame stop");

    property p_no_early_req;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(csr_req) |-> $past(launch);
    endproperty
    a_no_early_req: assert property (p_no_early_req)
        else $error("access started without a completed frame");

    property p_req_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        csr_req && !csr_done |=> csr_req && $stable(csr_addr);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped before answer");

    property p_dir_sel;
        @(posedge clk_sys) disable iff (!rst_n)
        csr_req |-> (csr_we == !cmd_q[CMD_RNW]);
    endproperty
    a_dir_sel: assert property (p_dir_sel)
        else $error("operation does not follow command bit four");

    property p_lanes;
        @(posedge clk_sys) disable iff (!rst_n)
        csr_req |-> (csr_be == cmd_q[3:0]) &&
            (csr_addr == {addr_hi_q, addr_lo_q});
    endproperty
    a_lanes: assert property (p_lanes)
        else $error("lane enables or address mismatch");

    property p_unclaimed_read_flag_set;
        @(posedge clk_sys) disable iff (!rst_n)
        csr_req && csr_done && !csr_claimed && !csr_we |=> unclaimed_read_flag_q;
    endproperty
    a_unclaimed_read_flag_set: assert property (p_unclaimed_read_flag_set)
        else $error("unclaimed read not flagged");

    property p_unclaimed_write_flag_set;
        @(posedge clk_sys) disable iff (!rst_n)
        csr_req && csr_done && !csr_claimed && csr_we |=> unclaimed_write_flag_q;
    endproperty
    a_unclaimed_write_flag_set: assert property (p_unclaimed_write_flag_set)
        else $error("unclaimed write not flagged");

    property p_flag_clear;
        @(posedge clk_sys) disable iff (!rst_n)
        tx_cmd_read |=> tx_valid && !unclaimed_read_flag_q && !unclaimed_write_flag_q &&
            tx_data[CMD_RD_FLAG] == $past(unclaimed_read_flag_q) &&
            tx_data[CMD_WR_FLAG] == $past(unclaimed_write_flag_q);
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("error flags not returned then cleared");

    property p_count;
        @(posedge clk_sys) disable iff (!rst_n)
        tx_req && tx_ok && tx_pos_q == POS_COUNT |=>
            tx_valid && tx_data == RET_COUNT;
    endproperty
    a_count: assert property (p_count)
        else $error("wrong block return count");

    property p_busy_nack;
        @(posedge clk_sys) disable iff (!rst_n)
        tx_req && state_q == S_WAIT |=> tx_nack && !tx_valid;
    endproperty
    a_busy_nack: assert property (p_busy_nack)
        else $error("return byte not refused while busy");
endmodule
`default_nettype wire

/* File: verilog/smcs_pkg.sv */
// constants and carrier types for the smbus csr access framer
//
// Operation
// - first byte after the slave address is the command code
// - byte count sits at position one for block transactions only
// - block read return sends count of following bytes, status included
// - byte count never includes the trailing pec byte
// - position two is the command byte: enables, operation, error flags
// - position three holds the low eight doubleword address bits
// - position four holds the upper six bits, fourteen bits total
// - top two bits of the upper address byte are ignored
// - data positions five to eight run least significant byte first
// - command bits zero to three enable data lanes zero to three
// - command bit four: zero writes, one reads
// - bit six flags an unclaimed read, cleared when returned
// - bit seven flags an unclaimed write, cleared when returned
// - flags only report whether the access was claimed
// - function field zero selects register access
// - size field: byte, word, block; three reserved
// - refuse new commands while busy or when data cannot be supplied
// - only the last doubleword of a long block is kept
package smcs_pkg;
    // byte positions in the framed sequence
    localparam logic [3:0] POS_COUNT = 4'h1;
    localparam logic [3:0] POS_CMD = 4'h2;
    localparam logic [3:0] POS_ADDR_LO = 4'h3;
    localparam logic [3:0] POS_ADDR_HI = 4'h4;
    localparam logic [3:0] POS_DATA_FIRST = 4'h5;
    localparam logic [3:0] POS_DATA_LAST = 4'h8;
    // command code fields
    localparam int CODE_END = 0;
    localparam int CODE_START = 1;
    localparam int CODE_FUNC_LSB = 2;
    localparam int CODE_FUNC_MSB = 4;
    localparam int CODE_SIZE_LSB = 5;
    localparam int CODE_SIZE_MSB = 6;
    localparam logic [2:0] FUNC_CSR = 3'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_BLOCK = 2'h2;
    localparam logic [1:0] SIZE_RSVD = 2'h3;
    // command byte fields
    localparam int CMD_RNW = 4;
    localparam int CMD_RD_FLAG = 6;
    localparam int CMD_WR_FLAG = 7;
    localparam int ADDR_HI_W = 6;
    // bytes after the count on a block read return: cmd, addr x2, data x4
    localparam logic [7:0] RET_COUNT = 8'h07;
    localparam int FIFO_DEPTH = 8;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_POS = 4'h2;

    typedef enum logic [1:0] {
        KIND_CODE,
        KIND_DATA,
        KIND_STOP
    } smcs_kind_type;

    // one entry from the smbus byte engine
    typedef struct packed {
        smcs_kind_type kind;
        logic [7:0] data;
    } smcs_rx_type;
endpackage

/* File: verilog/smcs_fifo.sv */
// small flop based fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module smcs_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == PTR_LAST) ? '0 : p + 1'b1;
    endfunction

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    // count; ready and valid are registered copies of the next count
    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_q <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            in_ready <= cnt_d != CNT_FULL;
            out_valid <= cnt_d != '0;
        end
    end

    // pointers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= bump(wr_q);
            end
            if (pop) begin
                rd_q <= bump(rd_q);
            end
        end
    end

    // storage needs no reset, entries are only read once valid
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule
`default_nettype wire

/* File: tb/smcs_csr_target.sv */
// csr target model that answers the framer's internal accesses
`timescale 1ns/1ps
`default_nettype none
module smcs_csr_target (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // access from the framer
    input wire logic csr_req,
    input wire logic csr_we,
    input wire logic [13:0] csr_addr,
    input wire logic [3:0] csr_be,
    input wire logic [31:0] csr_wdata,
    // behaviour chosen by the bench
    input wire logic [7:0] delay,
    input wire logic claim,
    // answer
    output logic csr_done,
    output logic csr_claimed,
    output logic [31:0] csr_rdata
);
    logic [31:0] mem_q [16];
    logic [7:0] cnt_q;

    // answer after delay cycles; off the answer cycle the data is scrambled
    // so a framer that samples one cycle late sees the inverted value
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            csr_done <= 1'b0;
            csr_claimed <= 1'b0;
            csr_rdata <= 32'h00000000;
            for (int i = 0; i < 16; i++) mem_q[i] <= 32'h00000000;
        end else if (csr_done) begin
            csr_done <= 1'b0;
            cnt_q <= 8'h00;
            csr_claimed <= ~csr_claimed;
            csr_rdata <= ~csr_rdata;
        end else if (csr_req && cnt_q >= delay) begin
            csr_done <= 1'b1;
            csr_claimed <= claim;
            csr_rdata <= mem_q[csr_addr[3:0]];
            // only enabled lanes of a claimed write land
            for (int i = 0; i < 4; i++) begin
                if (claim && csr_we && csr_be[i]) begin
                    mem_q[csr_addr[3:0]][8*i +: 8] <= csr_wdata[8*i +: 8];
                end
            end
        end else begin
            cnt_q <= csr_req ? cnt_q + 8'h01 : 8'h00;
            csr_rdata <= ~csr_rdata;
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the smbus csr access framer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import smcs_pkg::*;
    logic clk_sys, rst_n, rx_valid, rx_ready, tx_req, tx_valid, tx_nack;
    logic cmd_nack, csr_req, csr_we, csr_done, csr_claimed, claim, seen;
    smcs_rx_type rx_word;
    logic [7:0] tx_data, delay;
    logic [13:0] csr_addr;
    logic [3:0] csr_be;
    logic [31:0] csr_wdata, csr_rdata;
    int failures, n_tests;

    smcs_csr_access smcs_csr_access_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word),
        .tx_req(tx_req), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_nack(tx_nack), .cmd_nack(cmd_nack), .csr_req(csr_req),
        .csr_we(csr_we), .csr_addr(csr_addr), .csr_be(csr_be),
        .csr_wdata(csr_wdata), .csr_done(csr_done),
        .csr_claimed(csr_claimed), .csr_rdata(csr_rdata));
    smcs_csr_target smcs_csr_target_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .csr_req(csr_req), .csr_we(csr_we), .csr_addr(csr_addr),
        .csr_be(csr_be), .csr_wdata(csr_wdata), .delay(delay),
        .claim(claim), .csr_done(csr_done), .csr_claimed(csr_claimed),
        .csr_rdata(csr_rdata));

    // 100 mhz system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
        end
    endtask

    // one entry, held until the fifo has room; notes any back-pressure
    task automatic push(input smcs_kind_type k, input logic [7:0] d);
        int n;
        n = 0;
        rx_valid = 1'b1;
        rx_word.kind = k;
        rx_word.data = d;
        while (rx_ready !== 1'b1 && n < 300) begin
            seen = 1'b1;
            @(negedge clk_sys);
            n++;
        end
        chk(32'(rx_ready), 32'h1);
        @(negedge clk_sys);
    endtask

    task automatic frame(input logic [7:0] code, input logic [7:0] b[$]);
        push(KIND_CODE, code);
        foreach (b[i]) push(KIND_DATA, b[i]);
        chk(32'(csr_req), 32'h0);
        push(KIND_STOP, 8'h00);
        rx_valid = 1'b0;
    endtask

    // wait for the access, compare its fields, optionally its release
    task automatic launch(input logic [18:0] e, input logic [31:0] wd,
                          input logic rel);
        int n;
        n = 0;
        while (csr_req !== 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        chk(32'(csr_req), 32'h1);
        chk(32'({csr_we, csr_be, csr_addr}), 32'(e));
        if (csr_we === 1'b1) chk(csr_wdata, wd);
        n = 0;
        while (rel && csr_req !== 1'b0 && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
        if (rel) chk(32'(csr_req), 32'h0);
    endtask

    task automatic tx(input logic nk, input logic [7:0] e);
        int n;
        n = 0;
        tx_req = 1'b1;
        @(negedge clk_sys);
        tx_req = 1'b0;
        while (tx_valid !== 1'b1 && tx_nack !== 1'b1 && n < 4) begin
            @(negedge clk_sys);
            n++;
        end
        chk(32'(tx_valid), 32'(!nk));
        chk(32'(tx_nack), 32'(nk));
        if (!nk) chk(32'(tx_data), 32'(e));
        @(negedge clk_sys);
    endtask

    // block read: setup frame, access, then the returned sequence
    task automatic rd(input logic [7:0] lo, input logic [7:0] hi,
                      input logic [7:0] c, input logic [31:0] d);
        frame(8'h43, '{8'h03, 8'h1f, lo, hi});
        launch({1'b0, 4'hf, hi[5:0], lo}, 32'h0, 1'b1);
        push(KIND_CODE, 8'h43);
        rx_valid = 1'b0;
        repeat (3) @(negedge clk_sys);
        tx(1'b0, RET_COUNT);
        tx(1'b0, c);
        tx(1'b0, lo);
        tx(1'b0, {2'b00, hi[5:0]});
        for (int i = 0; i < 4; i++) tx(1'b0, d[8*i +: 8]);
    endtask

    task automatic summarize;
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // hang guard, far beyond the several hundred cycles the tests take
    initial begin
        #500000;
        failures++;
        summarize;
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        rx_valid = 1'b0;
        rx_word = '0;
        tx_req = 1'b0;
        delay = 8'h02;
        claim = 1'b1;
        seen = 1'b0;
        failures = 0;
        n_tests = 0;
        repeat (16) @(negedge clk_sys);
        chk(32'({csr_req, cmd_nack, tx_valid, tx_nack}), 32'h0);
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        frame(8'h43, '{8'h07, 8'h0f, 8'h05, 8'he9, 8'h44, 8'h33, 8'h22,
                       8'h11});
        launch({1'b1, 4'hf, 14'h2905}, 32'h11223344, 1'b1);
        frame(8'h23, '{8'h03, 8'h06, 8'h01, 8'hdd, 8'hcc, 8'hbb, 8'haa});
        launch({1'b1, 4'h3, 14'h0106}, 32'haabbccdd, 1'b1);
        frame(8'h03, '{8'h04, 8'h09, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04});
        launch({1'b1, 4'h4, 14'h0009}, 32'h04030201, 1'b1);
        frame(8'h43, '{8'h0b, 8'h0f, 8'h07, 8'h00, 8'h01, 8'h02, 8'h03,
                       8'h04, 8'h55, 8'h66, 8'h77, 8'h88});
        launch({1'b1, 4'hf, 14'h0007}, 32'h88776655, 1'b1);
        $display("test writes done");
        claim = 1'b0;
        frame(8'h43, '{8'h07, 8'h0f, 8'h05, 8'h29, 8'hef, 8'hbe, 8'had,
                       8'hde});
        launch({1'b1, 4'hf, 14'h2905}, 32'hdeadbeef, 1'b1);
        claim = 1'b1;
        rd(8'h05, 8'h29, 8'h9f, 32'h11223344);
        rd(8'h05, 8'h29, 8'h1f, 32'h11223344);
        rd(8'h06, 8'h01, 8'h1f, 32'h0000ccdd);
        rd(8'h09, 8'h00, 8'h1f, 32'h00030000);
        rd(8'h07, 8'h00, 8'h1f, 32'h88776655);
        claim = 1'b0;
        rd(8'h06, 8'h01, 8'h5f, 32'h0000ccdd);
        claim = 1'b1;
        rd(8'h06, 8'h01, 8'h1f, 32'h0000ccdd);
        $display("test reads and flags done");
        // slow target: refusals while busy, fifo fills behind the stall
        delay = 8'h28;
        seen = 1'b0;
        frame(8'h43, '{8'h07, 8'h0f, 8'h08, 8'h00, 8'h78, 8'h56, 8'h34,
                       8'h12});
        launch({1'b1, 4'hf, 14'h0008}, 32'h12345678, 1'b0);
        chk(32'(cmd_nack), 32'h1);
        tx(1'b1, 8'h00);
        frame(8'h43, '{8'h07, 8'h0f, 8'h0a, 8'h00, 8'h0d, 8'h0c, 8'h0b,
                       8'h0a});
        chk(32'(seen), 32'h1);
        launch({1'b1, 4'hf, 14'h000a}, 32'h0a0b0c0d, 1'b1);
        delay = 8'h02;
        rd(8'h08, 8'h00, 8'h1f, 32'h12345678);
        $display("test busy refusal done");
        // eeprom function and reserved size must not reach the target
        for (int i = 0; i < 2; i++) begin
            seen = 1'b0;
            frame(i ? 8'h63 : 8'h47, '{8'h06, 8'h0b, 8'h00, 8'h01, 8'h02,
                                       8'h03, 8'h04});
            repeat (20) begin
                @(negedge clk_sys);
                if (csr_req !== 1'b0) seen = 1'b1;
            end
            chk(32'(seen), 32'h0);
        end
        $display("test ignored codes done");
        summarize;
    end
endmodule
`default_nettype wire
